//--- dfss_params.svh
// constants for the serial-port transfer controller: offsets, fields, reset values
// assumes a 32-bit APB master; printed offsets are word indexes, byte address is four times the index
//
// Operation
// - tx_empty_flag at 1 starts a RAM-to-transmit-data copy and clears the flag.
// - rx_full_flag at 1 starts a receive-data-to-RAM copy and clears the flag.
// - after the programmed transfers complete, raise that channel's CPU interrupt.
// - xfer_mode_field 00 means normal mode; xfer_size_field 00 means byte transfers.
// - src_addr_mode 10 increments source_pointer per transfer; 00 keeps it fixed.
// - dst_addr_mode 10 increments dest_pointer per transfer; 00 keeps it fixed.
// - per_transfer_irq_select 0 interrupts the CPU once the count is finished.
// - chain_enable 0 means one activation performs exactly one transfer.
// - transfer_counter holds the number of transfers; 0x20 gives 32 bytes.
// - activation enable bit 0x0400 selects transmit-empty, 0x0800 selects receive-full.
// - skip_reread 0 reloads the transfer information on every activation.
// - sync_mode_select 1 puts the serial port in clock-synchronous operation.
// - char_length_select 0 gives 8 data bits per character.
// - clock source 00 uses the internal bit-rate clock, driven out on the clock pin.
// - tx_irq_enable gates the transmit-empty request: 1 passes, 0 suppresses.
// - rx_irq_enable gates both receive-full and receive-error requests.
// - transmitter runs only with tx_enable_bit 1, receiver only with rx_enable_bit 1; a running frame finishes if tx_enable_bit clears with rx_enable_bit 1.
// - serial status reads 0x84 after reset: empty and end flags set.
// - bit-rate value 124, undivided clock, gives 100 kbit/s; one bit is 4*(N+1) clocks.
// - each data bit is driven from one falling clock edge to the next.
// - bits go out LSB first; the line then holds the last bit.
`ifndef DFSS_PARAMS_SVH
`define DFSS_PARAMS_SVH
`define DFSS_IDX_ACT_EN 32'hfffe6008
`define DFSS_IDX_XFER_CTRL 32'hfffe6010
`define DFSS_IDX_VEC_BASE 32'hfffe6014
`define DFSS_IDX_SER_MODE 32'hffff9000
`define DFSS_IDX_BIT_RATE 32'hffff9002
`define DFSS_IDX_SER_CTRL 32'hffff9004
`define DFSS_IDX_SER_STAT 32'hffff9008
`define DFSS_IDX_TX_DATA 32'h00000010
`define DFSS_IDX_RX_DATA 32'h00000011
`define DFSS_IDX_INFO_BASE 32'h00000100
`define DFSS_IDX_RAM_BASE 32'h00000200
`define DFSS_ACT_TX_BIT 10
`define DFSS_ACT_RX_BIT 11
`define DFSS_CTRL_SKIP_BIT 3
`define DFSS_INFO_KIND_LSB 14
`define DFSS_INFO_SIZE_LSB 12
`define DFSS_INFO_SRC_LSB 10
`define DFSS_INFO_CHAIN_BIT 7
`define DFSS_INFO_EACH_IRQ_BIT 5
`define DFSS_INFO_DST_LSB 2
`define DFSS_ADDR_INC 2'b10
`define DFSS_SER_STAT_RESET 8'h84
`endif

//--- dfss_pkg.sv
// types shared by the serial-port transfer controller
// assumes nothing of its surroundings
`default_nettype none
package dfss_pkg;
  typedef enum logic [3:0] {
    DMA_IDLE = 4'b0001,
    DMA_LOAD = 4'b0010,
    DMA_MOVE = 4'b0100,
    DMA_WBACK = 4'b1000
  } dfss_dma_e;
endpackage : dfss_pkg
`default_nettype wire

//--- dfss_top.sv
// transfer controller feeding a clock-synchronous serial port, with 64-byte on-chip RAM
// assumes an APB master on clk_sys and a serial partner on clock/data pins sampled by clk_sys
`include "dfss_params.svh"
`timescale 1ns/1ns
`default_nettype none
module dfss_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic rxdIn,
  output logic txdOut,
  output logic txIrq,
  output logic rxIrq,
  output logic errIrq
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic hitIdx(input logic [29:0] a, input logic [31:0] k);
    return a == k[29:0];
  endfunction : hitIdx

  function automatic logic modeOk(input logic [15:0] m);
    return m[`DFSS_INFO_KIND_LSB +: 2] == 2'b00 && m[`DFSS_INFO_SIZE_LSB +: 2] == 2'b00;
  endfunction : modeOk

  logic [29:0] idx;
  logic setupPh;
  logic accPh;
  logic wrEn;
  logic [31:0] rdVal;
  logic rdOk;
  logic infoHit;
  logic ramHit;

  logic [15:0] actEn;
  logic [7:0] xferCtrl;
  logic [31:0] vecBase;
  logic [7:0] serMode;
  logic [7:0] bitRate;
  logic [7:0] serCtrl;
  logic [15:0] infoMode [0:1];
  logic [31:0] infoSrc [0:1];
  logic [31:0] infoDst [0:1];
  logic [15:0] infoCnt [0:1];
  logic [7:0] ram [0:63];

  logic txEmpty;
  logic rxFull;
  logic orer;
  logic tx_end_flag;
  logic [7:0] tdr;
  logic [7:0] rdr;

  dfss_pkg::dfss_dma_e state;
  dfss_pkg::dfss_dma_e next_state;
  logic ch;
  logic lastCh;
  logic lastValid;
  logic [15:0] wMode;
  logic [31:0] wSrc;
  logic [31:0] wDst;
  logic [15:0] wCnt;
  logic [1:0] donePend;

  assign idx = paddr[31:2];
  assign setupPh = psel & ~penable;
  assign accPh = psel & penable & pready;
  assign wrEn = accPh & pwrite & ~pslverr;
  assign infoHit = idx[29:3] == 27'(`DFSS_IDX_INFO_BASE >> 3);
  assign ramHit = idx[29:6] == 24'(`DFSS_IDX_RAM_BASE >> 6);

  // ----------------------------------------
  // APB slave: one access cycle, no wait states
  // ----------------------------------------
  always_comb
  begin
    rdVal = 32'h0;
    rdOk = 1'b1;
    if (hitIdx(idx, `DFSS_IDX_ACT_EN)) rdVal = {16'h0, actEn};
    else if (hitIdx(idx, `DFSS_IDX_XFER_CTRL)) rdVal = {24'h0, xferCtrl};
    else if (hitIdx(idx, `DFSS_IDX_VEC_BASE)) rdVal = vecBase;
    else if (hitIdx(idx, `DFSS_IDX_SER_MODE)) rdVal = {24'h0, serMode};
    else if (hitIdx(idx, `DFSS_IDX_BIT_RATE)) rdVal = {24'h0, bitRate};
    else if (hitIdx(idx, `DFSS_IDX_SER_CTRL)) rdVal = {24'h0, serCtrl};
    else if (hitIdx(idx, `DFSS_IDX_SER_STAT)) rdVal = {24'h0, txEmpty, rxFull, orer, 2'b00, tx_end_flag, 2'b00};
    else if (hitIdx(idx, `DFSS_IDX_TX_DATA)) rdVal = {24'h0, tdr};
    else if (hitIdx(idx, `DFSS_IDX_RX_DATA)) rdVal = {24'h0, rdr};
    else if (infoHit)
    begin
      case (idx[1:0])
        2'h0: rdVal = {16'h0, infoMode[idx[2]]};
        2'h1: rdVal = infoSrc[idx[2]];
        2'h2: rdVal = infoDst[idx[2]];
        default: rdVal = {16'h0, infoCnt[idx[2]]};
      endcase
    end
    else if (ramHit) rdVal = {24'h0, ram[idx[5:0]]};
    else rdOk = 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setupPh;
      pslverr <= setupPh & ~rdOk;
      if (setupPh) prdata <= rdOk ? rdVal : 32'h0;
    end
  end

  // ----------------------------------------
  // configuration and transfer information
  // ----------------------------------------
  logic canTx;
  logic canRx;
  logic startTx;
  logic startRx;
  logic doneEv;

  assign canTx = actEn[`DFSS_ACT_TX_BIT] && infoCnt[0] != 16'h0 && modeOk(infoMode[0]);
  assign canRx = actEn[`DFSS_ACT_RX_BIT] && infoCnt[1] != 16'h0 && modeOk(infoMode[1]);
  assign startTx = txEmpty & serCtrl[7] & canTx;
  assign startRx = rxFull & serCtrl[6] & canRx;
  // interrupt after every transfer when selected, otherwise only once the count runs out
  assign doneEv = state == dfss_pkg::DMA_WBACK && (wCnt == 16'h0 || wMode[`DFSS_INFO_EACH_IRQ_BIT]);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      actEn <= 16'h0;
      xferCtrl <= 8'h0;
      vecBase <= 32'h0;
      serMode <= 8'h0;
      bitRate <= 8'hff;
      serCtrl <= 8'h0;
      for (int i = 0; i < 2; i++)
      begin
        infoMode[i] <= 16'h0;
        infoSrc[i] <= 32'h0;
        infoDst[i] <= 32'h0;
        infoCnt[i] <= 16'h0;
      end
    end
    else
    begin
      if (wrEn && hitIdx(idx, `DFSS_IDX_ACT_EN)) actEn <= pwdata[15:0];
      if (wrEn && hitIdx(idx, `DFSS_IDX_XFER_CTRL)) xferCtrl <= pwdata[7:0];
      if (wrEn && hitIdx(idx, `DFSS_IDX_VEC_BASE)) vecBase <= pwdata;
      if (wrEn && hitIdx(idx, `DFSS_IDX_SER_MODE)) serMode <= pwdata[7:0];
      if (wrEn && hitIdx(idx, `DFSS_IDX_BIT_RATE)) bitRate <= pwdata[7:0];
      if (wrEn && hitIdx(idx, `DFSS_IDX_SER_CTRL)) serCtrl <= pwdata[7:0];
      if (wrEn && infoHit)
      begin
        case (idx[1:0])
          2'h0: infoMode[idx[2]] <= pwdata[15:0];
          2'h1: infoSrc[idx[2]] <= pwdata;
          2'h2: infoDst[idx[2]] <= pwdata;
          default: infoCnt[idx[2]] <= pwdata[15:0];
        endcase
      end
      // write-back wins over a software write landing in the same cycle
      if (state == dfss_pkg::DMA_WBACK)
      begin
        infoSrc[ch] <= wSrc;
        infoDst[ch] <= wDst;
        infoCnt[ch] <= wCnt;
        if (doneEv) actEn[ch ? `DFSS_ACT_RX_BIT : `DFSS_ACT_TX_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // transfer engine
  // ----------------------------------------
  always_comb
  begin
    case (state)
      dfss_pkg::DMA_IDLE: next_state = (startTx | startRx) ? dfss_pkg::DMA_LOAD : dfss_pkg::DMA_IDLE;
      dfss_pkg::DMA_LOAD: next_state = dfss_pkg::DMA_MOVE;
      dfss_pkg::DMA_MOVE: next_state = dfss_pkg::DMA_WBACK;
      // chaining is not offered: every activation ends after one byte
      dfss_pkg::DMA_WBACK: next_state = dfss_pkg::DMA_IDLE;
      default: next_state = dfss_pkg::DMA_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= dfss_pkg::DMA_IDLE;
      ch <= 1'b0;
    end
    else
    begin
      state <= next_state;
      // receive wins: a late receive byte overruns, a late transmit byte only stalls
      if (state == dfss_pkg::DMA_IDLE) ch <= startRx;
    end
  end

  logic dmaTxLoad;
  logic dmaRxStore;
  logic [7:0] ramRd;

  assign dmaTxLoad = state == dfss_pkg::DMA_MOVE && !ch;
  assign dmaRxStore = state == dfss_pkg::DMA_MOVE && ch;
  assign ramRd = ram[wSrc[5:0]];

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wMode <= 16'h0;
      wSrc <= 32'h0;
      wDst <= 32'h0;
      wCnt <= 16'h0;
      lastCh <= 1'b0;
      lastValid <= 1'b0;
    end
    else if (state == dfss_pkg::DMA_LOAD)
    begin
      if (!(xferCtrl[`DFSS_CTRL_SKIP_BIT] && lastValid && lastCh == ch))
      begin
        wMode <= infoMode[ch];
        wSrc <= infoSrc[ch];
        wDst <= infoDst[ch];
        wCnt <= infoCnt[ch];
      end
      lastCh <= ch;
      lastValid <= 1'b1;
    end
    else if (state == dfss_pkg::DMA_MOVE)
    begin
      if (wMode[`DFSS_INFO_SRC_LSB +: 2] == `DFSS_ADDR_INC) wSrc <= wSrc + 32'd1;
      if (wMode[`DFSS_INFO_DST_LSB +: 2] == `DFSS_ADDR_INC) wDst <= wDst + 32'd1;
      wCnt <= wCnt - 16'd1;
    end
  end

  // memory has no reset; software loads it before enabling a channel
  always_ff @(posedge clk_sys)
  begin
    if (dmaRxStore) ram[wDst[5:0]] <= rdr;
    else if (wrEn && ramHit) ram[idx[5:0]] <= pwdata[7:0];
  end

  chk_cnt_step: assert property (@(posedge clk_sys) disable iff (rst)
    state == dfss_pkg::DMA_MOVE |=> wCnt == $past(wCnt) - 16'd1)
    else $error("transfer count did not step down by one");
  chk_src_step: assert property (@(posedge clk_sys) disable iff (rst)
    state == dfss_pkg::DMA_MOVE && wMode[`DFSS_INFO_SRC_LSB +: 2] == `DFSS_ADDR_INC
    |=> wSrc == $past(wSrc) + 32'd1)
    else $error("source pointer did not increment");
  chk_dst_fixed: assert property (@(posedge clk_sys) disable iff (rst)
    state == dfss_pkg::DMA_MOVE && wMode[`DFSS_INFO_DST_LSB +: 2] == 2'b00 |=> $stable(wDst))
    else $error("fixed destination pointer moved");
  chk_start_gate: assert property (@(posedge clk_sys) disable iff (rst)
    state == dfss_pkg::DMA_IDLE && next_state == dfss_pkg::DMA_LOAD
    |-> infoCnt[startRx] != 16'h0 && actEn[startRx ? `DFSS_ACT_RX_BIT : `DFSS_ACT_TX_BIT])
    else $error("transfer started on a disabled or exhausted channel");
  chk_one_move: assert property (@(posedge clk_sys) disable iff (rst)
    state == dfss_pkg::DMA_LOAD |=> state == dfss_pkg::DMA_MOVE ##1 state == dfss_pkg::DMA_WBACK
    ##1 state == dfss_pkg::DMA_IDLE)
    else $error("activation did not end after one transfer");

  // ----------------------------------------
  // serial port: pins, bit clock, shifters
  // ----------------------------------------
  logic syncMode;
  logic intClk;
  logic [2:0] lastBit;
  logic sckS1;
  logic sckS2;
  logic sckD;
  logic rxS1;
  logic rxS2;
  logic [15:0] halfMax;
  logic [15:0] genCnt;
  logic tick;
  logic fall;
  logic rise;
  logic busy;
  logic txOn;
  logic rxOn;
  logic [2:0] bitCnt;
  logic [7:0] txShift;
  logic [7:0] rxShift;

  assign syncMode = serMode[7];
  assign lastBit = serMode[6] ? 3'd6 : 3'd7;
  assign intClk = ~serCtrl[1];
  // half bit = 2*(N+1)*4^n clocks, so a bit takes 4*(N+1)*4^n clocks
  assign halfMax = (16'(bitRate) + 16'd1) << {serMode[1:0], 1'b1};
  assign tick = busy && intClk && genCnt == halfMax - 16'd1;
  assign fall = intClk ? (tick & sckOut) : (sckD & ~sckS2);
  assign rise = intClk ? (tick & ~sckOut) : (~sckD & sckS2);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sckS1 <= 1'b1;
      sckS2 <= 1'b1;
      sckD <= 1'b1;
      rxS1 <= 1'b1;
      rxS2 <= 1'b1;
    end
    else
    begin
      sckS1 <= sckIn;
      sckS2 <= sckS1;
      sckD <= sckS2;
      rxS1 <= rxdIn;
      rxS2 <= rxS1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || !busy || !intClk)
    begin
      genCnt <= 16'h0;
      sckOut <= 1'b1;
    end
    else if (tick)
    begin
      genCnt <= 16'h0;
      sckOut <= ~sckOut;
    end
    else genCnt <= genCnt + 16'd1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst) sckOe <= 1'b0;
    else sckOe <= syncMode & intClk;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      txEmpty <= 1'b1;
      rxFull <= 1'b0;
      orer <= 1'b0;
      tx_end_flag <= 1'b1;
      tdr <= 8'h0;
      rdr <= 8'h0;
      txShift <= 8'h0;
      rxShift <= 8'h0;
      txdOut <= 1'b1;
      busy <= 1'b0;
      txOn <= 1'b0;
      rxOn <= 1'b0;
      bitCnt <= 3'd0;
    end
    else
    begin
      // software clears first so that any hardware set below wins
      if (wrEn && hitIdx(idx, `DFSS_IDX_SER_STAT))
      begin
        if (!pwdata[7]) txEmpty <= 1'b0;
        if (!pwdata[6]) rxFull <= 1'b0;
        if (!pwdata[5]) orer <= 1'b0;
      end
      if (wrEn && hitIdx(idx, `DFSS_IDX_TX_DATA)) tdr <= pwdata[7:0];
      if (dmaTxLoad)
      begin
        tdr <= ramRd;
        txEmpty <= 1'b0;
      end
      if (dmaRxStore) rxFull <= 1'b0;
      if (!busy)
      begin
        if (syncMode && ((serCtrl[5] && !txEmpty) || (serCtrl[4] && !serCtrl[5] && !rxFull)))
        begin
          busy <= 1'b1;
          bitCnt <= 3'd0;
          txOn <= serCtrl[5];
          rxOn <= serCtrl[4];
          if (serCtrl[5])
          begin
            txShift <= tdr;
            txEmpty <= 1'b1;
            tx_end_flag <= 1'b0;
          end
        end
      end
      else if (!(serCtrl[5] || serCtrl[4])) busy <= 1'b0;
      else
      begin
        if (fall && txOn)
        begin
          txdOut <= txShift[0];
          txShift <= {1'b0, txShift[7:1]};
        end
        if (rise)
        begin
          rxShift <= {rxS2, rxShift[7:1]};
          bitCnt <= bitCnt + 3'd1;
          if (bitCnt == lastBit)
          begin
            busy <= 1'b0;
            if (rxOn && serCtrl[4])
            begin
              if (rxFull && !dmaRxStore) orer <= 1'b1;
              else
              begin
                rdr <= serMode[6] ? {1'b0, rxS2, rxShift[7:2]} : {rxS2, rxShift[7:1]};
                rxFull <= 1'b1;
              end
            end
            if (txOn && (txEmpty || !serCtrl[5])) tx_end_flag <= 1'b1;
          end
        end
      end
    end
  end

  sequence s_tx_move;
    state == dfss_pkg::DMA_MOVE && !ch;
  endsequence
  sequence s_rx_move;
    state == dfss_pkg::DMA_MOVE && ch;
  endsequence

  chk_tx_flag_clear: assert property (@(posedge clk_sys) disable iff (rst)
    s_tx_move |=> !txEmpty && tdr == $past(ramRd))
    else $error("transmit copy did not load data and clear the empty flag");
  chk_rx_flag_clear: assert property (@(posedge clk_sys) disable iff (rst)
    s_rx_move ##1 !$past(busy && rise && bitCnt == lastBit) |-> !rxFull)
    else $error("receive copy did not clear the full flag");
  chk_txd_on_fall: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(txdOut) |-> $past(fall) && $past(txOn))
    else $error("transmit line changed away from a falling clock edge");
  chk_stat_reset: assert property (@(posedge clk_sys)
    rst |=> {txEmpty, rxFull, orer, 2'b00, tx_end_flag, 2'b00} == `DFSS_SER_STAT_RESET)
    else $error("serial status not at its reset value");

  // ----------------------------------------
  // CPU requests
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      donePend <= 2'b00;
      txIrq <= 1'b0;
      rxIrq <= 1'b0;
      errIrq <= 1'b0;
    end
    else
    begin
      if (wrEn && hitIdx(idx, `DFSS_IDX_SER_STAT)) donePend <= 2'b00;
      if (doneEv) donePend[ch] <= 1'b1;
      txIrq <= serCtrl[7] & ((txEmpty & ~canTx) | donePend[0]);
      rxIrq <= serCtrl[6] & ((rxFull & ~canRx) | donePend[1]);
      errIrq <= serCtrl[6] & orer;
    end
  end

  sequence s_tx_done;
    doneEv && !ch && serCtrl[7] ##1 serCtrl[7];
  endsequence

  chk_done_irq: assert property (@(posedge clk_sys) disable iff (rst)
    s_tx_done |=> txIrq)
    else $error("no CPU request after the transmit count completed");
  chk_rx_gate: assert property (@(posedge clk_sys) disable iff (rst)
    !serCtrl[6] |=> !rxIrq && !errIrq)
    else $error("receive request passed with its enable cleared");
  chk_tx_gate: assert property (@(posedge clk_sys) disable iff (rst)
    !serCtrl[7] |=> !txIrq)
    else $error("transmit request passed with its enable cleared");

endmodule : dfss_top
`default_nettype wire

//--- dfss_serial_peer.sv
// serial peer model: external clock-synchronous device on the clock and data pins
// assumes the controller supplies the serial clock, idling high between frames
`timescale 1ns/1ns
`default_nettype none
module dfss_serial_peer (
  input wire logic armed,
  input wire logic sck,
  input wire logic txd,
  output logic rxd
);
  logic [7:0] gotByte [0:63];
  logic [7:0] shiftIn = 8'h00;
  logic [7:0] cur = 8'h00;
  int gotCount = 0;
  int bitIdx = 0;
  int badEdge = 0;
  initial rxd = 1'b0;
  // ----------------------------------------
  // receive side of the controller
  // ----------------------------------------
  function automatic logic [7:0] sendByte(input int k);
    return 8'h5a ^ 8'(k);
  endfunction : sendByte
  // drive on the falling edge so the bit is settled long before the rising edge
  always @(negedge sck)
  begin
    if (armed)
    begin
      cur = sendByte(gotCount);
      rxd <= cur[bitIdx];
    end
  end
  // ----------------------------------------
  // transmit side: lsb arrives first
  // ----------------------------------------
  always @(posedge sck)
  begin
    if (armed && gotCount < 64)
    begin
      shiftIn = {txd, shiftIn[7:1]};
      bitIdx++;
      if (bitIdx == 8)
      begin
        gotByte[gotCount] = shiftIn;
        gotCount++;
        bitIdx = 0;
        // released line must not look like a held copy of the last bit
        rxd <= ~rxd;
      end
    end
  end
  // data and clock move on the same system edge: look once both have settled
  always @(txd)
  begin
    if (armed)
    begin
      #1;
      if (sck === 1'b1)
        badEdge++;
    end
  end
endmodule : dfss_serial_peer
`default_nettype wire

//--- dfss_top_test.sv
// testbench: programs the controller over APB, runs 32 bytes each way, checks RAM and link
// assumes the serial peer model on the pins and internal clock mode
`include "dfss_params.svh"
`timescale 1ns/1ns
`default_nettype none
module dfss_top_test;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sckOut, sckOe, txdOut, txIrq, rxIrq, errIrq, rxdIn;
  logic armed = 1'b0;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int checks = 0;
  int n;
  int lowRun = 0;
  int lowMax = 0;
  wire logic sckPin = sckOe ? sckOut : 1'b1;
  always #25 clk_sys = ~clk_sys;
  // longest low phase of the link clock, in system clocks
  always @(posedge clk_sys)
  begin
    if (sckPin === 1'b0)
      lowRun++;
    else
    begin
      if (lowRun > lowMax)
        lowMax = lowRun;
      lowRun = 0;
    end
  end
  dfss_top dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sckIn(sckPin), .sckOut(sckOut), .sckOe(sckOe), .rxdIn(rxdIn), .txdOut(txdOut),
    .txIrq(txIrq), .rxIrq(rxIrq), .errIrq(errIrq));
  dfss_serial_peer peer_u (.armed(armed), .sck(sckPin), .txd(txdOut), .rxd(rxdIn));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] txPat(input int k);
    return 8'hc3 ^ 8'(k * 5);
  endfunction : txPat
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("checks %0d errors %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  // one transfer; entered just after a rising edge, leaves one edge after release
  task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] wd,
      output logic [31:0] q, output logic e);
    int w;
    w = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= idx << 2;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      w++;
    end
    while (pready !== 1'b1 && w < 50);
    if (w >= 50)
    begin
      fail_count++;
      results();
    end
    else
    begin
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
    end
  endtask : apb
  task automatic wr(input logic [31:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd, rd, err);
  endtask : wr
  task automatic rdChk(input logic [31:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, rd, err);
    check(rd, exp);
  endtask : rdChk
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    armed <= 1'b1;
    @(posedge clk_sys);
    rdChk(`DFSS_IDX_SER_STAT, 32'h84);
    apb(1'b0, 32'h0000048d, 32'h0, rd, err);
    check({31'h0, err}, 32'h1);
    wr(`DFSS_IDX_SER_CTRL, 32'h00);
    wr(`DFSS_IDX_SER_MODE, 32'h80);
    wr(`DFSS_IDX_BIT_RATE, 32'h01);
    wr(`DFSS_IDX_XFER_CTRL, 32'h00);
    for (int k = 0; k < 32; k++)
      wr(`DFSS_IDX_RAM_BASE + k, {24'h0, txPat(k)});
    wr(`DFSS_IDX_INFO_BASE, 32'h0800);
    wr(`DFSS_IDX_INFO_BASE + 1, 32'h00);
    wr(`DFSS_IDX_INFO_BASE + 2, 32'h10);
    wr(`DFSS_IDX_INFO_BASE + 3, 32'h20);
    wr(`DFSS_IDX_INFO_BASE + 4, 32'h0008);
    wr(`DFSS_IDX_INFO_BASE + 5, 32'h11);
    wr(`DFSS_IDX_INFO_BASE + 6, 32'h20);
    wr(`DFSS_IDX_INFO_BASE + 7, 32'h20);
    wr(`DFSS_IDX_ACT_EN, 32'h0c00);
    wr(`DFSS_IDX_SER_CTRL, 32'hf0);
    check({31'h0, sckOe}, 32'h1);
    n = 0;
    while (!(txIrq === 1'b1 && rxIrq === 1'b1) && n < 20000)
    begin
      @(posedge clk_sys);
      n++;
    end
    check(n < 20000, 32'h1);
    check(peer_u.gotCount, 32'd32);
    for (int k = 0; k < 32; k++)
    begin
      check({24'h0, peer_u.gotByte[k]}, {24'h0, txPat(k)});
      rdChk(`DFSS_IDX_RAM_BASE + 32 + k, {24'h0, 8'h5a ^ 8'(k)});
    end
    apb(1'b0, `DFSS_IDX_INFO_BASE + 1, 32'h0, rd, err);
    check({26'h0, rd[5:0]}, 32'h20);
    rdChk(`DFSS_IDX_INFO_BASE + 2, 32'h10);
    rdChk(`DFSS_IDX_INFO_BASE + 3, 32'h00);
    rdChk(`DFSS_IDX_INFO_BASE + 5, 32'h11);
    apb(1'b0, `DFSS_IDX_INFO_BASE + 6, 32'h0, rd, err);
    check({26'h0, rd[5:0]}, 32'h00);
    rdChk(`DFSS_IDX_INFO_BASE + 7, 32'h00);
    rdChk(`DFSS_IDX_ACT_EN, 32'h00);
    rdChk(`DFSS_IDX_SER_STAT, 32'h84);
    check({31'h0, errIrq}, 32'h0);
    check(peer_u.badEdge, 32'd0);
    check(lowMax, 32'd4);
    check({31'h0, txdOut}, {24'h0, txPat(31)} >> 7);
    wr(`DFSS_IDX_SER_CTRL, 32'h30);
    repeat (2) @(posedge clk_sys);
    check({30'h0, txIrq, rxIrq}, 32'h0);
    wr(`DFSS_IDX_SER_CTRL, 32'h00);
    wr(`DFSS_IDX_SER_STAT, 32'h00);
    rdChk(`DFSS_IDX_SER_STAT, 32'h04);
    results();
  end
endmodule : dfss_top_test
`default_nettype wire
